//--- include/rph_pkg.sv
// package of constants and types for the receiver-port and pin control register bank
package rph_pkg;

	// register byte addresses
	localparam logic [7:0] RPH_OFS_RX_PORT   = 8'h0c;
	localparam logic [7:0] RPH_OFS_IO_SUPPLY = 8'h0d;
	localparam logic [7:0] RPH_OFS_PIN_STS   = 8'h0e;
	localparam logic [7:0] RPH_OFS_PIN_IN    = 8'h0f;

	// field positions
	localparam int RPH_LOCK_SEL_LSB = 2;
	localparam int RPH_RX1_BIT      = 1;
	localparam int RPH_RX0_BIT      = 0;
	localparam int RPH_RX_RSVD_LSB  = 6;
	localparam int RPH_LEVEL_BIT    = 7;
	localparam int RPH_OVR_BIT      = 6;
	localparam int RPH_MODE_LSB     = 4;
	localparam int RPH_IO_RSVD_LSB  = 0;
	localparam int RPH_NPINS        = 7;

	// values after reset and fixed read values
	localparam logic [1:0] RPH_RX_RSVD_VAL  = 2'h2;
	localparam logic [1:0] RPH_LOCK_SEL_RST = 2'h0;
	localparam logic [3:0] RPH_IO_RSVD_RST  = 4'h9;
	localparam logic [6:0] RPH_PIN_IN_RST   = 7'h7f;

	// supply mode codes; 2'h1 and 2'h2 are reserved
	localparam logic [1:0] RPH_MODE_1V8 = 2'h0;
	localparam logic [1:0] RPH_MODE_3V3 = 2'h3;

	// 7-bit target address, value arbitrary
	localparam logic [6:0] RPH_I2C_ADDR = 7'h3d;
	localparam logic [3:0] RPH_BYTE_BITS = 4'h8;
	localparam logic [3:0] RPH_LAST_BIT  = 4'h7;

	typedef enum logic [1:0] {
		LOCK_PORT0 = 2'b00,
		LOCK_PORT1 = 2'b01,
		LOCK_ANY   = 2'b10,
		LOCK_ALL   = 2'b11
	} rph_lock_sel_type;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_RECV = 3'b001,
		ST_ACK  = 3'b010,
		ST_SEND = 3'b011,
		ST_MACK = 3'b100
	} rph_st_type;

	typedef struct packed {
		logic       valid;
		logic [7:0] addr;
		logic [7:0] data;
	} rph_wr_type;

	typedef struct packed {
		logic [1:0] lock_sel;
		logic       rx_channel1_on;
		logic       rx_channel0_on;
		logic       io_level_select;
		logic       supply_setting_override;
		logic [1:0] supply_mode;
		logic [3:0] io_rsvd;
		logic [6:0] pin_input_on;
	} rph_cfg_type;

	localparam rph_cfg_type RPH_CFG_RST = '{
		lock_sel:                RPH_LOCK_SEL_RST,
		rx_channel1_on:          1'b1,
		rx_channel0_on:          1'b1,
		io_level_select:         1'b0,
		supply_setting_override: 1'b0,
		supply_mode:             RPH_MODE_1V8,
		io_rsvd:                 RPH_IO_RSVD_RST,
		pin_input_on:            RPH_PIN_IN_RST
	};

endpackage : rph_pkg

//--- core/rph_sync.sv
// two-flop synchroniser for asynchronous pin inputs
`timescale 1ns/1ps
module rph_sync #(
	parameter int W = 1
) (
	input  wire logic         i_clk,    // core clock
	input  wire logic         i_arst_n, // async reset, active low
	input  wire logic [W-1:0] i_d,      // asynchronous inputs
	output logic      [W-1:0] o_q       // synchronised outputs
);

	logic [W-1:0] meta_r;
	logic [W-1:0] meta_nxt;
	logic [W-1:0] q_r;
	logic [W-1:0] q_nxt;

	always_comb begin
		meta_nxt = i_d;
		q_nxt    = meta_r;
	end

	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			meta_r <= '0;
			q_r    <= '0;
		end else begin
			meta_r <= meta_nxt;
			q_r    <= q_nxt;
		end
	end

	assign o_q = q_r;

endmodule : rph_sync

//--- core/rph_regs.sv
// receiver-port, supply and pin control register bank behind an i2c target
`timescale 1ns/1ps
module rph_regs
	import rph_pkg::*;
(
	input  wire logic       i_core_clk,         // core clock, 250 MHz
	input  wire logic       i_arst_n,           // async reset, active low
	input  wire logic       i_scl,              // i2c clock pin level
	input  wire logic       i_sda,              // i2c data pin level
	output logic            o_sda,              // i2c data drive value, always low
	output logic            o_sda_oe,           // i2c data pulled low while high
	input  rph_wr_type      i_remote_wr,        // write from the remote control path
	input  wire logic [1:0] i_rx_lock,          // per-port receiver lock
	input  wire logic       i_io_detect_3v3,    // detected i/o level, 1 is 3.3V
	input  wire logic [6:0] i_gpio,             // gpio pin levels
	output logic            o_lock,             // selected lock indication
	output logic [1:0]      o_rx_channel_on,    // receiver enables, bit n is port n
	output logic            o_io_level_select,  // applied level select
	output logic [1:0]      o_supply_mode,      // applied supply mode
	output logic [6:0]      o_pin_input_on      // per-pin input path enables
);

	logic [9:0] sync_q;
	logic       scl_s, sda_s, det_s;
	logic [6:0] gpio_s;
	// bus pins pass inverted, so the zero reset of the flops reads as idle high
	rph_sync #(.W(10)) u_sync (
		.i_clk    (i_core_clk),
		.i_arst_n (i_arst_n),
		.i_d      ({~i_scl, ~i_sda, i_io_detect_3v3, i_gpio}),
		.o_q      (sync_q)
	);
	assign {scl_s, sda_s, det_s, gpio_s} = {~sync_q[9:8], sync_q[7:0]};

	// register write; remote path never reaches the lock selector
	function automatic rph_cfg_type apply_wr(input rph_cfg_type c, input rph_wr_type w,
		input logic local_wr);
		rph_cfg_type r;
		r = c;
		if (w.valid) begin
			case (w.addr)
				RPH_OFS_RX_PORT: begin
					if (local_wr) r.lock_sel = w.data[RPH_LOCK_SEL_LSB +: 2];
					r.rx_channel1_on = w.data[RPH_RX1_BIT];
					r.rx_channel0_on = w.data[RPH_RX0_BIT];
				end
				RPH_OFS_IO_SUPPLY: begin
					r.io_level_select         = w.data[RPH_LEVEL_BIT];
					r.supply_setting_override = w.data[RPH_OVR_BIT];
					r.supply_mode             = w.data[RPH_MODE_LSB +: 2];
					r.io_rsvd                 = w.data[RPH_IO_RSVD_LSB +: 4];
				end
				RPH_OFS_PIN_IN: begin
					r.pin_input_on = w.data[RPH_NPINS-1:0];
				end
				default: ;
			endcase
		end
		return r;
	endfunction : apply_wr

	function automatic logic [1:0] det_mode(input logic det);
		return det ? RPH_MODE_3V3 : RPH_MODE_1V8;
	endfunction : det_mode
	function automatic logic [7:0] rd_byte(input logic [7:0] a, input rph_cfg_type c,
		input logic det, input logic [6:0] pins);
		logic [7:0] d;
		d = 8'h00;
		case (a)
			RPH_OFS_RX_PORT: begin
				d[RPH_RX_RSVD_LSB +: 2] = RPH_RX_RSVD_VAL;
				d[RPH_LOCK_SEL_LSB +: 2] = c.lock_sel;
				d[RPH_RX1_BIT] = c.rx_channel1_on;
				d[RPH_RX0_BIT] = c.rx_channel0_on;
			end
			RPH_OFS_IO_SUPPLY: begin
				d[RPH_LEVEL_BIT] = c.supply_setting_override ? c.io_level_select : det;
				d[RPH_OVR_BIT] = c.supply_setting_override;
				d[RPH_MODE_LSB +: 2] = c.supply_setting_override ? c.supply_mode
					: det_mode(det);
				d[RPH_IO_RSVD_LSB +: 4] = c.io_rsvd;
			end
			RPH_OFS_PIN_STS: begin
				// disabled input paths read low
				d[RPH_NPINS-1:0] = pins & c.pin_input_on;
			end
			RPH_OFS_PIN_IN: begin
				d[RPH_NPINS-1:0] = c.pin_input_on;
			end
			default: ;
		endcase
		return d;
	endfunction : rd_byte

	// i2c target state
	rph_st_type  st_r, st_nxt;
	logic        scl_prev_r, sda_prev_r;
	logic [3:0]  bit_cnt_r, bit_cnt_nxt;
	logic [7:0]  shift_r, shift_nxt;
	logic [1:0]  byte_idx_r, byte_idx_nxt;
	logic        rd_r, rd_nxt;
	logic        acked_r, acked_nxt;
	logic [7:0]  ptr_r, ptr_nxt;
	logic        oe_r, oe_nxt;
	rph_wr_type  i2c_wr;
	logic [7:0]  rd_data;
	logic        scl_rise, scl_fall, start_cond, stop_cond;
	rph_cfg_type cfg_r, cfg_nxt;

	assign scl_rise   = scl_s & ~scl_prev_r;
	assign scl_fall   = ~scl_s & scl_prev_r;
	assign start_cond = scl_s & scl_prev_r & sda_prev_r & ~sda_s;
	assign stop_cond  = scl_s & scl_prev_r & ~sda_prev_r & sda_s;
	// sampled at load time, so each status read sees the pins of that moment
	assign rd_data    = rd_byte(ptr_r, cfg_r, det_s, gpio_s);
	always_comb begin
		st_nxt       = st_r;
		bit_cnt_nxt  = bit_cnt_r;
		shift_nxt    = shift_r;
		byte_idx_nxt = byte_idx_r;
		rd_nxt       = rd_r;
		acked_nxt    = acked_r;
		ptr_nxt      = ptr_r;
		oe_nxt       = oe_r;
		i2c_wr       = '0;
		if (stop_cond) begin
			st_nxt = ST_IDLE;
			oe_nxt = 1'b0;
		end else if (start_cond) begin
			st_nxt       = ST_RECV;
			bit_cnt_nxt  = 4'h0;
			byte_idx_nxt = 2'h0;
			oe_nxt       = 1'b0;
		end else begin
			case (st_r)
				ST_RECV: begin
					if (scl_rise && bit_cnt_r < RPH_BYTE_BITS) begin
						shift_nxt   = {shift_r[6:0], sda_s};
						bit_cnt_nxt = bit_cnt_r + 4'h1;
					end else if (scl_fall && bit_cnt_r == RPH_BYTE_BITS) begin
						bit_cnt_nxt = 4'h0;
						if (byte_idx_r != 2'h0 || shift_r[7:1] == RPH_I2C_ADDR) begin
							st_nxt = ST_ACK;
							oe_nxt = 1'b1;
							if (byte_idx_r == 2'h0) rd_nxt = shift_r[0];
						end else begin
							st_nxt = ST_IDLE;
						end
					end
				end
				ST_ACK: begin
					if (scl_fall) begin
						oe_nxt = 1'b0;
						st_nxt = ST_RECV;
						if (byte_idx_r == 2'h0) begin
							byte_idx_nxt = 2'h1;
							if (rd_r) begin
								shift_nxt = rd_data;
								ptr_nxt   = ptr_r + 8'h01;
								oe_nxt    = ~rd_data[7];
								st_nxt    = ST_SEND;
							end
						end else if (byte_idx_r == 2'h1) begin
							ptr_nxt      = shift_r;
							byte_idx_nxt = 2'h2;
						end else begin
							i2c_wr  = '{valid: 1'b1, addr: ptr_r, data: shift_r};
							ptr_nxt = ptr_r + 8'h01;
						end
					end
				end
				ST_SEND: begin
					if (scl_fall) begin
						if (bit_cnt_r == RPH_LAST_BIT) begin
							oe_nxt      = 1'b0;
							bit_cnt_nxt = 4'h0;
							st_nxt      = ST_MACK;
						end else begin
							shift_nxt   = {shift_r[6:0], 1'b0};
							bit_cnt_nxt = bit_cnt_r + 4'h1;
							oe_nxt      = ~shift_r[6];
						end
					end
				end
				ST_MACK: begin
					if (scl_rise) begin
						acked_nxt = ~sda_s;
					end else if (scl_fall) begin
						if (acked_r) begin
							shift_nxt = rd_data;
							ptr_nxt   = ptr_r + 8'h01;
							oe_nxt    = ~rd_data[7];
							st_nxt    = ST_SEND;
						end else begin
							st_nxt = ST_IDLE;
						end
					end
				end
				default: begin
					st_nxt = ST_IDLE;
				end
			endcase
		end
	end
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_r       <= ST_IDLE;
			scl_prev_r <= 1'b1;
			sda_prev_r <= 1'b1;
			bit_cnt_r  <= 4'h0;
			shift_r    <= 8'h00;
			byte_idx_r <= 2'h0;
			rd_r       <= 1'b0;
			acked_r    <= 1'b0;
			ptr_r      <= 8'h00;
			oe_r       <= 1'b0;
		end else begin
			st_r       <= st_nxt;
			scl_prev_r <= scl_s;
			sda_prev_r <= sda_s;
			bit_cnt_r  <= bit_cnt_nxt;
			shift_r    <= shift_nxt;
			byte_idx_r <= byte_idx_nxt;
			rd_r       <= rd_nxt;
			acked_r    <= acked_nxt;
			ptr_r      <= ptr_nxt;
			oe_r       <= oe_nxt;
		end
	end

	// local write applied last so it wins a same-cycle clash
	always_comb begin
		cfg_nxt = apply_wr(apply_wr(cfg_r, i_remote_wr, 1'b0), i2c_wr, 1'b1);
	end
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cfg_r <= RPH_CFG_RST;
		end else begin
			cfg_r <= cfg_nxt;
		end
	end

	// applied controls
	logic       lock_r, lock_nxt;
	logic       level_r, level_nxt;
	logic [1:0] mode_r, mode_nxt;
	logic [1:0] en_v;
	assign en_v = {cfg_r.rx_channel1_on, cfg_r.rx_channel0_on};

	always_comb begin
		case (rph_lock_sel_type'(cfg_r.lock_sel))
			LOCK_PORT0: lock_nxt = i_rx_lock[0];
			LOCK_PORT1: lock_nxt = i_rx_lock[1];
			LOCK_ANY:   lock_nxt = |(i_rx_lock & en_v);
			// no enabled port means no lock
			LOCK_ALL:   lock_nxt = (|en_v) & (&(i_rx_lock | ~en_v));
			default:    lock_nxt = 1'b0;
		endcase
		level_nxt = cfg_r.supply_setting_override ? cfg_r.io_level_select : det_s;
		mode_nxt  = cfg_r.supply_setting_override ? cfg_r.supply_mode
			: det_mode(det_s);
	end
	always_ff @(posedge i_core_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			lock_r  <= 1'b0;
			level_r <= 1'b0;
			mode_r  <= RPH_MODE_1V8;
		end else begin
			lock_r  <= lock_nxt;
			level_r <= level_nxt;
			mode_r  <= mode_nxt;
		end
	end
	assign o_sda             = 1'b0;
	assign o_sda_oe          = oe_r;
	assign o_lock            = lock_r;
	assign o_rx_channel_on   = en_v;
	assign o_io_level_select = level_r;
	assign o_supply_mode     = mode_r;
	assign o_pin_input_on    = cfg_r.pin_input_on;

endmodule : rph_regs

//--- tb/rph_regs_asserts.sv
// port-side assertions for the register bank
`timescale 1ns/1ps
module rph_regs_asserts
	import rph_pkg::*;
(
	input  wire logic       i_core_clk,      // core clock
	input  wire logic       i_arst_n,        // async reset, active low
	input  wire logic       i_scl,           // i2c clock pin
	input  rph_wr_type      i_remote_wr,     // remote write
	input  wire logic [1:0] i_rx_lock,       // per-port lock
	input  wire logic       o_sda_oe,        // sda pull enable
	input  wire logic       o_lock,          // selected lock
	input  wire logic [1:0] o_rx_channel_on, // receiver enables
	input  wire logic [6:0] o_pin_input_on   // input enables
);
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_arst_n);
	// raw scl high means no i2c commit is near, so remote writes stand alone
	lock_all_a: assert property ($past(i_arst_n) && $past(i_rx_lock) == 2'b11 &&
		$past(o_rx_channel_on) != 2'b00 |-> o_lock) else $error("lock low while all locked");
	lock_none_a: assert property ($past(i_rx_lock) == 2'b00 |-> !o_lock)
		else $error("lock high while none locked");
	ack_edge_a: assert property ($changed(o_sda_oe) |-> !i_scl)
		else $error("sda drive moved while scl high");
	ack_bound_a: assert property ($rose(o_sda_oe) |-> ##[1:250] !o_sda_oe)
		else $error("sda held low too long");
	chan_write_a: assert property (
		i_scl && i_remote_wr.valid && i_remote_wr.addr == RPH_OFS_RX_PORT
		|=> o_rx_channel_on == $past(i_remote_wr.data[1:0]))
		else $error("enables not written");
	chan_hold_a: assert property (
		i_scl && !(i_remote_wr.valid && i_remote_wr.addr == RPH_OFS_RX_PORT)
		|=> $stable(o_rx_channel_on))
		else $error("enables moved unasked");
	pin_write_a: assert property (
		i_scl && i_remote_wr.valid && i_remote_wr.addr == RPH_OFS_PIN_IN
		|=> o_pin_input_on == $past(i_remote_wr.data[6:0]))
		else $error("input enables not written");
	pin_hold_a: assert property (
		i_scl && !(i_remote_wr.valid && i_remote_wr.addr == RPH_OFS_PIN_IN)
		|=> $stable(o_pin_input_on))
		else $error("input enables moved unasked");
endmodule : rph_regs_asserts

bind rph_regs rph_regs_asserts u_asserts (
	.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_scl(i_scl), .i_remote_wr(i_remote_wr),
	.i_rx_lock(i_rx_lock), .o_sda_oe(o_sda_oe), .o_lock(o_lock),
	.o_rx_channel_on(o_rx_channel_on), .o_pin_input_on(o_pin_input_on)
);

//--- tb/rph_host.sv
// i2c controller model on the host side of the register bank
`timescale 1ns/1ps
module rph_host
	import rph_pkg::*;
(
	input  wire logic i_core_clk, // core clock, paces the bus
	input  wire logic i_sda,      // resolved sda wire
	output logic      o_scl,      // scl drive
	output logic      o_sda       // sda drive, 1 releases
);
	localparam int HALF = 10;
	initial begin
		o_scl = 1'b1;
		o_sda = 1'b1;
	end
	task automatic tick(input int n);
		repeat (n) @(negedge i_core_clk);
	endtask : tick
	task automatic start();
		o_sda = 1'b1;
		tick(HALF);
		o_scl = 1'b1;
		tick(HALF);
		o_sda = 1'b0;
		tick(HALF);
		o_scl = 1'b0;
		tick(2);
	endtask : start
	task automatic stop();
		o_sda = 1'b0;
		tick(HALF);
		o_scl = 1'b1;
		tick(HALF);
		o_sda = 1'b1;
		tick(HALF);
	endtask : stop
	// sda moves two cycles after scl falls, never while scl is high
	task automatic xfer(input logic [8:0] d, output logic [8:0] q);
		for (int i = 8; i >= 0; i--) begin
			o_sda = d[i];
			tick(HALF);
			o_scl = 1'b1;
			tick(HALF);
			q[i] = i_sda;
			o_scl = 1'b0;
			tick(2);
		end
	endtask : xfer
	task automatic wr(input logic [7:0] a, input logic [7:0] d, output logic nak);
		logic [8:0] q0, q1, q2;
		start();
		xfer({RPH_I2C_ADDR, 1'b0, 1'b1}, q0);
		xfer({a, 1'b1}, q1);
		xfer({d, 1'b1}, q2);
		stop();
		nak = q0[0] | q1[0] | q2[0];
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		logic [8:0] q;
		start();
		xfer({RPH_I2C_ADDR, 1'b0, 1'b1}, q);
		xfer({a, 1'b1}, q);
		start();
		xfer({RPH_I2C_ADDR, 1'b1, 1'b1}, q);
		xfer(9'h1ff, q);
		stop();
		d = q[8:1];
	endtask : rd
endmodule : rph_host

//--- tb/rph_regs_tb.sv
// self-checking bench for the register bank
`timescale 1ns/1ps
module rph_regs_tb
	import rph_pkg::*;
;
	logic       i_core_clk = 1'b0;
	logic       i_arst_n, scl, sda_host, sda_wire, o_sda, o_sda_oe, o_lock, lvl, det;
	logic [1:0] i_rx_lock, chan, mode;
	logic [6:0] gpio, pin_on;
	rph_wr_type i_remote_wr;
	int         n_errors = 0;
	int         compares = 0;
	int         cycles = 0;

	always #2 i_core_clk = ~i_core_clk;
	assign sda_wire = o_sda_oe ? (sda_host & o_sda) : sda_host;

	rph_host host (.i_core_clk(i_core_clk), .i_sda(sda_wire), .o_scl(scl), .o_sda(sda_host));
	rph_regs dut (
		.i_core_clk(i_core_clk), .i_arst_n(i_arst_n), .i_scl(scl), .i_sda(sda_wire),
		.o_sda(o_sda), .o_sda_oe(o_sda_oe), .i_remote_wr(i_remote_wr), .i_rx_lock(i_rx_lock),
		.i_io_detect_3v3(det), .i_gpio(gpio), .o_lock(o_lock), .o_rx_channel_on(chan),
		.o_io_level_select(lvl), .o_supply_mode(mode), .o_pin_input_on(pin_on)
	);

	task automatic complete_run();
		$display("compares %0d errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : complete_run
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic nak;
		host.wr(a, d, nak);
		chk({7'h00, nak}, 8'h00);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] d;
		host.rd(a, d);
		chk(d, exp);
	endtask : rd
	task automatic rwr(input logic [7:0] a, input logic [7:0] d);
		i_remote_wr = '{valid: 1'b1, addr: a, data: d};
		@(negedge i_core_clk);
		i_remote_wr = '0;
		@(negedge i_core_clk);
	endtask : rwr
	function automatic logic lock_exp(input logic [1:0] c, input logic [1:0] l, input logic [1:0] en);
		case (c)
			2'h0: return l[0];
			2'h1: return l[1];
			2'h2: return |(l & en);
			default: return (en != 2'h0) && ((l & en) == en);
		endcase
	endfunction : lock_exp
	task automatic sweep(input logic [1:0] c, input logic [1:0] en);
		for (int l = 0; l < 4; l++) begin
			i_rx_lock = l[1:0];
			repeat (3) @(negedge i_core_clk);
			chk({7'h00, o_lock}, {7'h00, lock_exp(c, l[1:0], en)});
		end
	endtask : sweep

	always @(posedge i_core_clk) begin
		cycles++;
		if (cycles == 60000) begin
			n_errors++;
			complete_run();
		end
	end

	initial begin
		i_arst_n = 1'b0;
		i_rx_lock = 2'h0;
		det = 1'b0;
		gpio = 7'h00;
		i_remote_wr = '0;
		repeat (5) @(negedge i_core_clk);
		i_arst_n = 1'b1;
		repeat (8) @(negedge i_core_clk);
		chk({6'h00, chan}, 8'h03);
		chk({1'b0, pin_on}, 8'h7f);
		chk({5'h00, lvl, mode}, 8'h00);
		rd(RPH_OFS_RX_PORT, 8'h83);
		rd(RPH_OFS_IO_SUPPLY, 8'h09);
		rd(RPH_OFS_PIN_IN, 8'h7f);
		det = 1'b1;
		repeat (6) @(negedge i_core_clk);
		chk({5'h00, lvl, mode}, 8'h07);
		rd(RPH_OFS_IO_SUPPLY, 8'hb9);
		wr(RPH_OFS_IO_SUPPLY, 8'h40);
		chk({5'h00, lvl, mode}, 8'h00);
		rd(RPH_OFS_IO_SUPPLY, 8'h40);
		det = 1'b0;
		wr(RPH_OFS_IO_SUPPLY, 8'hf0);
		chk({5'h00, lvl, mode}, 8'h07);
		rd(RPH_OFS_IO_SUPPLY, 8'hf0);
		for (int c = 0; c < 4; c++) begin
			wr(RPH_OFS_RX_PORT, {4'h0, c[1:0], 2'h3});
			rd(RPH_OFS_RX_PORT, {4'h8, c[1:0], 2'h3});
			sweep(c[1:0], 2'h3);
		end
		// remote path may move the enables but not the lock selector
		rwr(RPH_OFS_RX_PORT, 8'h01);
		chk({6'h00, chan}, 8'h01);
		rd(RPH_OFS_RX_PORT, 8'h8d);
		sweep(2'h3, 2'h1);
		rwr(RPH_OFS_RX_PORT, 8'h02);
		sweep(2'h3, 2'h2);
		gpio = 7'h55;
		repeat (6) @(negedge i_core_clk);
		rd(RPH_OFS_PIN_STS, 8'h55);
		wr(RPH_OFS_PIN_IN, 8'hff);
		rd(RPH_OFS_PIN_IN, 8'h7f);
		wr(RPH_OFS_PIN_IN, 8'h0f);
		chk({1'b0, pin_on}, 8'h0f);
		rd(RPH_OFS_PIN_STS, 8'h05);
		gpio = 7'h2a;
		repeat (6) @(negedge i_core_clk);
		wr(RPH_OFS_PIN_STS, 8'hff);
		rd(RPH_OFS_PIN_STS, 8'h0a);
		rwr(RPH_OFS_PIN_IN, 8'h7f);
		rd(RPH_OFS_PIN_STS, 8'h2a);
		rd(8'h20, 8'h00);
		complete_run();
	end
endmodule : rph_regs_tb
